// [design/wim_pkg.sv]
// Purpose: Constants for the wake input monitor: register map, field codes, timing.
// Assumes: Plain register port with 8-bit data, one system clock.
// Notes: Channels 0..2 are the wake pins, channels 3..4 the fail-safe inputs.
//
// Behaviour
// (R1) Both rising and falling crossings signal events
// (R2) Interrupt in Normal/Stop, wake-up in Sleep/Fail-Safe
// (R3) Static sense continuous, cyclic sense timer-windowed
// (R4) Static sense offers 16 or 64 us deglitch
// (R5) Crossing restarts filter; accept if stable throughout
// (R6) Per-pin wake enable written by software
// (R7) Per-pin wake-source flag, readable any time
// (R8) Pin levels readable in Normal/Stop, always
// (R9) Cyclic sense reports most recently sampled level
// (R10) Fail-safe inputs: fixed 16 us, separate status
// (R11) Current-source code 00: none, reset default
// (R12) Code 01 pull-down, code 10 pull-up
// (R13) Code 11 follows detected level automatically
// (R14) Filter code 00 static 16, 01 static 64
// (R15) Codes 10/11 cyclic on timer A/B, 16 us
// (R16) Software assigns timer to a high-side output; here the windows come in on i_timer_a_on and i_timer_b_on
// (R17) Synchronise inputs, count filter in clock cycles
// (R18) Wake flags stay set until software clears

package wim_pkg;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  localparam int unsigned NUM_WAKE = 3;
  localparam int unsigned NUM_ALT = 2;
  localparam int unsigned NUM_CH = 5;
  localparam int unsigned FIELD_W = 2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_WAKE_EN = 8'h00;
  localparam logic [7:0] ADDR_SRC_STAT = 8'h01;
  localparam logic [7:0] ADDR_LVL_STAT = 8'h02;
  localparam logic [7:0] ADDR_PUPD = 8'h03;
  localparam logic [7:0] ADDR_FLT = 8'h04;
  localparam logic [7:0] ADDR_ALT_STAT = 8'h05;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h06;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] WAKE_EN_RST = 3'h0;
  localparam logic [5:0] PUPD_RST = 6'h00;
  localparam logic [5:0] FLT_RST = 6'h00;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;

  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PUPD_NONE = 2'h0;
  localparam logic [1:0] PUPD_DOWN = 2'h1;
  localparam logic [1:0] PUPD_UP = 2'h2;
  localparam logic [1:0] PUPD_AUTO = 2'h3;
  localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
  localparam logic [1:0] FLT_STATIC_LONG = 2'h1;
  localparam logic [1:0] FLT_CYCLIC_A = 2'h2;
  localparam logic [1:0] FLT_CYCLIC_B = 2'h3;

  // ----------------------------------------------------------------
  // Device modes on i_dev_mode
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_STOP = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_FAILSAFE = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned FILT_SHORT_US = 16;
  localparam int unsigned FILT_LONG_US = 64;
  // Enabled edges after reset; the last one takes the settled pin level as reference
  localparam logic [1:0] SYNC_SETTLE = 2'h3;

endpackage

// [design/wim_wake_input_monitor.sv]
// Purpose: Deglitched edge detection on three wake pins and two fail-safe inputs.
// Assumes: Comparator outputs arrive asynchronous; timer windows come from outside.
// Notes: Flags are write-one-to-clear; a set in the clearing cycle wins.

`timescale 1ns/1ps
`default_nettype none

module wim_wake_input_monitor #(
  parameter int unsigned CLK_MHZ = 10,
  parameter int unsigned CNT_W = 10
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [2:0] i_wake_pin,
  input wire logic [1:0] i_fs_pin,
  input wire logic i_fs_wake_sel,
  input wire logic [1:0] i_dev_mode,
  input wire logic i_timer_a_on,
  input wire logic i_timer_b_on,
  output logic [2:0] o_pull_up,
  output logic [2:0] o_pull_down,
  output logic o_irq,
  output logic o_wake_req
);

  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(wim_pkg::FILT_SHORT_US * CLK_MHZ - 1);
  localparam logic [CNT_W-1:0] LONG_LAST = CNT_W'(wim_pkg::FILT_LONG_US * CLK_MHZ - 1);

  if (CLK_MHZ == 0 || wim_pkg::FILT_LONG_US * CLK_MHZ > (2 ** CNT_W)) begin : g_chk
    $error("CNT_W too small for the long filter at this clock rate");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] filt_last(input logic [1:0] code);
    filt_last = (code == wim_pkg::FLT_STATIC_LONG) ? LONG_LAST : SHORT_LAST;
  endfunction

  function automatic logic is_cyclic(input logic [1:0] code);
    is_cyclic = (code == wim_pkg::FLT_CYCLIC_A) || (code == wim_pkg::FLT_CYCLIC_B);
  endfunction

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [2:0] wake_en_reg;
  logic [5:0] pupd_reg;
  logic [5:0] flt_reg;
  logic [4:0] irq_mask_reg;
  logic [2:0] src_flag_reg;
  logic [1:0] alt_flag_reg;
  logic [2:0] lvl_reg;
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] acc_lvl_reg;
  logic [CNT_W-1:0] cnt_reg [wim_pkg::NUM_CH];
  logic [1:0] seed_reg;
  logic seeded;
  logic [4:0] ch_active;
  logic [4:0] ch_cyclic;
  logic [CNT_W-1:0] ch_last [wim_pkg::NUM_CH];
  logic [4:0] acc_ev;
  logic [4:0] ev_en;
  logic [2:0] src_clr;
  logic [1:0] alt_clr;
  logic [2:0] src_flag_next;
  logic [1:0] alt_flag_next;
  logic mode_awake;
  logic mode_asleep;

  assign mode_awake = (i_dev_mode == wim_pkg::MODE_NORMAL) || (i_dev_mode == wim_pkg::MODE_STOP);
  assign mode_asleep = !mode_awake;
  assign seeded = (seed_reg == wim_pkg::SYNC_SETTLE);

  // ----------------------------------------------------------------
  // Channel configuration
  // ----------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < wim_pkg::NUM_CH; k++) begin
      if (k < wim_pkg::NUM_WAKE) begin
        ch_cyclic[k] = is_cyclic(flt_reg[k*wim_pkg::FIELD_W +: 2]);
        ch_last[k] = filt_last(flt_reg[k*wim_pkg::FIELD_W +: 2]); // R4 R14 R15
        if (flt_reg[k*wim_pkg::FIELD_W +: 2] == wim_pkg::FLT_CYCLIC_A) begin
          ch_active[k] = i_timer_a_on; // R3 R15
        end else if (flt_reg[k*wim_pkg::FIELD_W +: 2] == wim_pkg::FLT_CYCLIC_B) begin
          ch_active[k] = i_timer_b_on; // R3 R15
        end else begin
          ch_active[k] = 1'b1; // R3
        end
      end else begin
        ch_cyclic[k] = 1'b0;
        ch_last[k] = SHORT_LAST; // R10
        ch_active[k] = i_fs_wake_sel; // R10
      end
    end
  end

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else if (i_clk_en) begin
      sync1_reg <= {i_fs_pin, i_wake_pin}; // R17
      sync2_reg <= sync1_reg; // R17
    end
  end

  // Waits for the synchroniser to fill before taking the first level
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      seed_reg <= 2'h0;
    end else if (i_clk_en && !seeded) begin
      seed_reg <= seed_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Deglitch filter
  // ----------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < wim_pkg::NUM_CH; k++) begin
      acc_ev[k] = seeded && ch_active[k] && (sync2_reg[k] != acc_lvl_reg[k])
        && (cnt_reg[k] == ch_last[k]); // R1 R5
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      acc_lvl_reg <= 5'h00;
      for (int k = 0; k < wim_pkg::NUM_CH; k++) begin
        cnt_reg[k] <= '0;
      end
    end else if (i_clk_en) begin
      for (int k = 0; k < wim_pkg::NUM_CH; k++) begin
        if (!seeded) begin
          acc_lvl_reg[k] <= sync2_reg[k];
          cnt_reg[k] <= '0;
        end else if (!ch_active[k] || (sync2_reg[k] == acc_lvl_reg[k])) begin
          cnt_reg[k] <= '0; // R5
        end else if (acc_ev[k]) begin
          acc_lvl_reg[k] <= sync2_reg[k]; // R1
          cnt_reg[k] <= '0;
        end else begin
          cnt_reg[k] <= cnt_reg[k] + CNT_W'(1); // R17
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wake_en_reg <= wim_pkg::WAKE_EN_RST;
      pupd_reg <= wim_pkg::PUPD_RST; // R11
      flt_reg <= wim_pkg::FLT_RST;
      irq_mask_reg <= wim_pkg::IRQ_MASK_RST;
    end else if (i_clk_en && i_wr) begin
      unique case (i_addr)
        wim_pkg::ADDR_WAKE_EN: wake_en_reg <= i_wdata[2:0]; // R6
        wim_pkg::ADDR_PUPD: pupd_reg <= i_wdata[5:0];
        wim_pkg::ADDR_FLT: flt_reg <= i_wdata[5:0];
        wim_pkg::ADDR_IRQ_MASK: irq_mask_reg <= i_wdata[4:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wake flags
  // ----------------------------------------------------------------
  assign src_clr = (i_wr && i_addr == wim_pkg::ADDR_SRC_STAT) ? i_wdata[2:0] : 3'h0;
  assign alt_clr = (i_wr && i_addr == wim_pkg::ADDR_ALT_STAT) ? i_wdata[1:0] : 2'h0;
  assign ev_en = {acc_ev[4:3], acc_ev[2:0] & wake_en_reg}; // R6
  assign src_flag_next = (src_flag_reg & ~src_clr) | ev_en[2:0]; // R7 R18
  assign alt_flag_next = (alt_flag_reg & ~alt_clr) | ev_en[4:3]; // R10 R18

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      src_flag_reg <= 3'h0;
      alt_flag_reg <= 2'h0;
    end else if (i_clk_en) begin
      src_flag_reg <= src_flag_next; // R7 R18
      alt_flag_reg <= alt_flag_next; // R10
    end
  end

  // ----------------------------------------------------------------
  // Level status
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lvl_reg <= 3'h0;
    end else if (i_clk_en && mode_awake) begin
      for (int k = 0; k < wim_pkg::NUM_WAKE; k++) begin
        if (!ch_cyclic[k] || ch_active[k]) begin
          lvl_reg[k] <= sync2_reg[k]; // R8 R9
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Current sources
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pull_up <= 3'h0;
      o_pull_down <= 3'h0;
    end else if (i_clk_en) begin
      for (int k = 0; k < wim_pkg::NUM_WAKE; k++) begin
        unique case (pupd_reg[k*wim_pkg::FIELD_W +: 2])
          wim_pkg::PUPD_NONE: begin
            o_pull_up[k] <= 1'b0; // R11
            o_pull_down[k] <= 1'b0; // R11
          end
          wim_pkg::PUPD_DOWN: begin
            o_pull_up[k] <= 1'b0;
            o_pull_down[k] <= 1'b1; // R12
          end
          wim_pkg::PUPD_UP: begin
            o_pull_up[k] <= 1'b1; // R12
            o_pull_down[k] <= 1'b0;
          end
          wim_pkg::PUPD_AUTO: begin
            o_pull_up[k] <= acc_lvl_reg[k]; // R13
            o_pull_down[k] <= !acc_lvl_reg[k]; // R13
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and wake-up
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
      o_wake_req <= 1'b0;
    end else if (i_clk_en) begin
      o_irq <= mode_awake && |({alt_flag_next, src_flag_next} & irq_mask_reg); // R2
      o_wake_req <= mode_asleep && |ev_en; // R2
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else if (i_clk_en && i_rd) begin
      unique case (i_addr)
        wim_pkg::ADDR_WAKE_EN: o_rdata <= {5'h00, wake_en_reg};
        wim_pkg::ADDR_SRC_STAT: o_rdata <= {5'h00, src_flag_reg}; // R7
        wim_pkg::ADDR_LVL_STAT: o_rdata <= {5'h00, lvl_reg}; // R8
        wim_pkg::ADDR_PUPD: o_rdata <= {2'h0, pupd_reg};
        wim_pkg::ADDR_FLT: o_rdata <= {2'h0, flt_reg};
        wim_pkg::ADDR_ALT_STAT: o_rdata <= {6'h00, alt_flag_reg}; // R10
        wim_pkg::ADDR_IRQ_MASK: o_rdata <= {3'h0, irq_mask_reg};
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);

  a_edge_toggles_level: assert property ( // R1
    (i_clk_en && acc_ev[0]) |=> (acc_lvl_reg[0] != $past(acc_lvl_reg[0])))
    else $error("accepted edge did not flip the level");

  a_sleep_wakes_device: assert property ( // R2
    (i_clk_en && mode_asleep && |ev_en) |=> o_wake_req)
    else $error("enabled event in low-power mode gave no wake-up");

  a_irq_only_awake: assert property ( // R2
    (i_clk_en && mode_asleep) |=> !o_irq)
    else $error("interrupt raised outside Normal or Stop");

  a_window_gates_count: assert property ( // R3
    (i_clk_en && seeded && !ch_active[1]) |=> (cnt_reg[1] == '0))
    else $error("filter counted outside the active window");

  a_filter_full_length: assert property ( // R5
    acc_ev[0] |-> (cnt_reg[0] == ch_last[0]) && $stable(sync2_reg[0]))
    else $error("event accepted before filter time expired");

  a_short_filter_code: assert property ( // R14
    (flt_reg[1:0] != wim_pkg::FLT_STATIC_LONG) |-> (ch_last[0] == SHORT_LAST))
    else $error("wrong filter length selected");

  a_disabled_no_flag: assert property ( // R6
    (i_clk_en && !wake_en_reg[2] && !src_flag_reg[2]) |=> !src_flag_reg[2])
    else $error("disabled pin set its wake flag");

  a_flag_sticky: assert property ( // R18
    (i_clk_en && src_flag_reg[0] && !src_clr[0]) |=> src_flag_reg[0])
    else $error("wake flag dropped without a clear");

  a_flag_set_wins: assert property ( // R7
    (i_clk_en && ev_en[1]) |=> src_flag_reg[1])
    else $error("enabled event did not set its flag");

  a_cyclic_holds_level: assert property ( // R9
    (i_clk_en && ch_cyclic[0] && !ch_active[0]) |=> $stable(lvl_reg[0]))
    else $error("cyclic level changed outside the window");

  a_alt_event_flag: assert property ( // R10
    (i_clk_en && acc_ev[3]) |=> alt_flag_reg[0])
    else $error("fail-safe input event not flagged");

  a_pull_float: assert property ( // R11
    (i_clk_en && pupd_reg[1:0] == wim_pkg::PUPD_NONE) |=> !o_pull_up[0] && !o_pull_down[0])
    else $error("current source on with code none");

  a_pull_auto: assert property ( // R13
    (i_clk_en && pupd_reg[5:4] == wim_pkg::PUPD_AUTO) |=> (o_pull_up[2] == $past(acc_lvl_reg[2])))
    else $error("automatic pull does not follow level");

  a_pull_down_code: assert property ( // R12
    (i_clk_en && pupd_reg[1:0] == wim_pkg::PUPD_DOWN) |=> o_pull_down[0] && !o_pull_up[0])
    else $error("pull-down not applied for its code");

  a_timer_b_window: assert property ( // R15
    (i_clk_en && seeded && flt_reg[1:0] == wim_pkg::FLT_CYCLIC_B && !i_timer_b_on)
      |=> (cnt_reg[0] == '0))
    else $error("timer B channel counted outside its window");

  a_level_follows_pin: assert property ( // R8
    (i_clk_en && mode_awake && !ch_cyclic[2]) |=> (lvl_reg[2] == $past(sync2_reg[2])))
    else $error("level status does not follow the pin");

  a_wake_only_asleep: assert property ( // R2
    (i_clk_en && mode_awake) |=> !o_wake_req)
    else $error("wake-up request raised in Normal or Stop");

  a_flag_clear: assert property ( // R7
    (i_clk_en && src_clr[0] && !ev_en[0]) |=> !src_flag_reg[0])
    else $error("written one did not clear the wake flag");

  a_enable_freezes: assert property (
    !i_clk_en |=> $stable(src_flag_reg) && $stable(o_rdata) && $stable(cnt_reg[0]))
    else $error("state changed while the clock enable was low");

  c_rise_accept: cover property (acc_ev[0] && sync2_reg[0]);
  c_cyclic_accept: cover property (acc_ev[0] && ch_cyclic[0]);
  c_fall_accept: cover property (acc_ev[0] && !sync2_reg[0]);
  c_wake_out: cover property (o_wake_req);
  c_irq_out: cover property (o_irq);

endmodule // wim_wake_input_monitor

`default_nettype wire

// [bench/wim_switch_model.sv]
// Purpose: Switch circuit on the three wake pins, with the pins' own pull sources.
// Assumes: A closed contact overrides the weak pull currents.
// Notes: An open contact with no pull floats and flips every cycle.
`timescale 1ns/1ps
`default_nettype none
module wim_switch_model (
  input wire logic i_sys_clk,
  input wire logic [2:0] i_drive,
  input wire logic [2:0] i_contact,
  input wire logic [2:0] i_pull_up,
  input wire logic [2:0] i_pull_down,
  output logic [2:0] o_pin
);
  logic [2:0] float_reg = 3'h5;
  always_ff @(posedge i_sys_clk) begin
    float_reg <= ~o_pin;
  end
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      if (i_drive[k]) begin
        o_pin[k] = i_contact[k];
      end else if (i_pull_up[k]) begin
        o_pin[k] = 1'b1;
      end else if (i_pull_down[k]) begin
        o_pin[k] = 1'b0;
      end else begin
        o_pin[k] = float_reg[k];
      end
    end
  end
endmodule // wim_switch_model
`default_nettype wire

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the wake input monitor.
// Assumes: Filters shortened by CLK_MHZ=1 to 16 and 64 cycles.
// Notes: Register traffic through plain strobe tasks.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int NS = 16;
  localparam int NL = 64;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [1:0] fs_pin = 2'h0;
  logic fs_sel = 1'b0;
  logic [1:0] mode = 2'h0;
  logic ta = 1'b0;
  logic tb_on = 1'b0;
  logic clk_en = 1'b1;
  logic [2:0] pu;
  logic [2:0] pd;
  logic [2:0] pin;
  logic [2:0] drive = 3'h7;
  logic [2:0] contact = 3'h0;
  logic irq;
  logic wreq;
  logic [7:0] n_wake = 8'h00;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  wim_wake_input_monitor #(.CLK_MHZ(1), .CNT_W(10)) wim_wake_input_monitor_i (
    .i_sys_clk(clk), .i_rstn(rstn), .i_clk_en(clk_en), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_wake_pin(pin), .i_fs_pin(fs_pin),
    .i_fs_wake_sel(fs_sel), .i_dev_mode(mode), .i_timer_a_on(ta), .i_timer_b_on(tb_on),
    .o_pull_up(pu), .o_pull_down(pd), .o_irq(irq), .o_wake_req(wreq));
  wim_switch_model wim_switch_model_i (
    .i_sys_clk(clk), .i_drive(drive), .i_contact(contact), .i_pull_up(pu),
    .i_pull_down(pd), .o_pin(pin));
  // --------------------------------------------------------------
  // Clock, timeout, wake pulse count
  // --------------------------------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (wreq === 1'b1) begin
      n_wake <= n_wake + 8'h01;
    end
    if (cycles == 5000) begin
      n_fail++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end
  end
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic irq_is(input logic v);
    chk({7'h0, irq}, {7'h0, v});
  endtask
  task automatic set_pin(input int k, input logic v);
    @(posedge clk);
    contact[k] <= v;
  endtask
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    cyc(4);
    for (int a = 0; a < 8; a++) begin
      rd_chk(a[7:0], 8'h00);
    end
    chk({2'h0, pu, pd}, 8'h00);
    wr_reg(wim_pkg::ADDR_WAKE_EN, 8'h07);
    wr_reg(wim_pkg::ADDR_IRQ_MASK, 8'h1f);
    wr_reg(wim_pkg::ADDR_PUPD, 8'h39);
    cyc(2);
    chk({2'h0, pu, pd}, 8'h15);
    @(posedge clk);
    drive <= 3'h4;
    cyc(NS + 4);
    rd_chk(wim_pkg::ADDR_SRC_STAT, 8'h02);
    rd_chk(wim_pkg::ADDR_LVL_STAT, 8'h02);
    cyc(20);
    rd_chk(wim_pkg::ADDR_SRC_STAT, 8'h02);
    irq_is(1'b1);
    wr_reg(wim_pkg::ADDR_SRC_STAT, 8'h02);
    rd_chk(wim_pkg::ADDR_SRC_STAT, 8'h00);
    irq_is(1'b0);
    set_pin(2, 1'b1);
    cyc(8);
    set_pin(2, 1'b0);
    cyc(NS + 4);
    rd_chk(wim_pkg::ADDR_SRC_STAT, 8'h00);
    set_pin(2, 1'b1);
    cyc(NS);
    irq_is(1'b0);
    cyc(4);
    irq_is(1'b1);
    chk({5'h0, pu}, 8'h06);
    rd_chk(wim_pkg::ADDR_SRC_STAT, 8'h04);
    wr_reg(wim_pkg::ADDR_SRC_STAT, 8'h04);
    set_pin(2, 1'b0);
    cyc(NS + 4);
    rd_chk(wim_pkg::ADDR_SRC_STAT, 8'h04);
    chk({5'h0, pd}, 8'h05);
    wr_reg(wim_pkg::ADDR_SRC_STAT, 8'h04);
    wr_reg(wim_pkg::ADDR_FLT, 8'h10);
    set_pin(2, 1'b1);
    cyc(NS + 8);
    irq_is(1'b0);
    cyc(NL - NS);
    irq_is(1'b1);
    wr_reg(wim_pkg::ADDR_SRC_STAT, 8'h04);
    wr_reg(wim_pkg::ADDR_WAKE_EN, 8'h03);
    rd_chk(wim_pkg::ADDR_LVL_STAT, 8'h06);
    set_pin(2, 1'b0);
    cyc(NL + 8);
    rd_chk(wim_pkg::ADDR_SRC_STAT, 8'h00);
    rd_chk(wim_pkg::ADDR_LVL_STAT, 8'h02);
    wr_reg(wim_pkg::ADDR_WAKE_EN, 8'h07);
    wr_reg(wim_pkg::ADDR_IRQ_MASK, 8'h1e);
    @(posedge clk);
    drive <= 3'h5;
    contact[0] <= 1'b1;
    cyc(NS + 4);
    irq_is(1'b0);
    rd_chk(wim_pkg::ADDR_SRC_STAT, 8'h01);
    wr_reg(wim_pkg::ADDR_SRC_STAT, 8'h01);
    wr_reg(wim_pkg::ADDR_IRQ_MASK, 8'h1f);
    for (int m = 1; m < 4; m++) begin
      @(posedge clk);
      mode <= m[1:0];
      contact[0] <= ~contact[0];
      cyc(NS + 4);
      irq_is(m < 2);
      chk(n_wake, (m < 2) ? 8'h00 : 8'(m - 1));
      wr_reg(wim_pkg::ADDR_SRC_STAT, 8'h01);
    end
    @(posedge clk);
    mode <= wim_pkg::MODE_NORMAL;
    wr_reg(wim_pkg::ADDR_FLT, 8'h02);
    set_pin(0, 1'b1);
    cyc(NL);
    irq_is(1'b0);
    rd_chk(wim_pkg::ADDR_LVL_STAT, 8'h02);
    @(posedge clk);
    ta <= 1'b1;
    cyc(NS + 4);
    irq_is(1'b1);
    rd_chk(wim_pkg::ADDR_LVL_STAT, 8'h03);
    wr_reg(wim_pkg::ADDR_FLT, 8'h03);
    wr_reg(wim_pkg::ADDR_SRC_STAT, 8'h01);
    @(posedge clk);
    ta <= 1'b0;
    tb_on <= 1'b1;
    contact[0] <= 1'b0;
    cyc(NS + 4);
    irq_is(1'b1);
    wr_reg(wim_pkg::ADDR_SRC_STAT, 8'h01);
    @(posedge clk);
    fs_sel <= 1'b1;
    fs_pin <= 2'h1;
    cyc(NS + 4);
    rd_chk(wim_pkg::ADDR_ALT_STAT, 8'h01);
    irq_is(1'b1);
    wr_reg(wim_pkg::ADDR_ALT_STAT, 8'h01);
    rd_chk(wim_pkg::ADDR_ALT_STAT, 8'h00);
    // Mid-run reset with pin 0 high: its start-up level is no event
    @(posedge clk);
    rstn <= 1'b0;
    fs_sel <= 1'b0;
    drive <= 3'h7;
    contact <= 3'h1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    wr_reg(wim_pkg::ADDR_WAKE_EN, 8'h07);
    cyc(NS + 8);
    rd_chk(wim_pkg::ADDR_SRC_STAT, 8'h00);
    rd_chk(wim_pkg::ADDR_LVL_STAT, 8'h01);
    // Clock enable low: write, read and filter all frozen
    @(posedge clk);
    clk_en <= 1'b0;
    contact[1] <= 1'b1;
    wr_reg(wim_pkg::ADDR_WAKE_EN, 8'h00);
    rd_chk(wim_pkg::ADDR_SRC_STAT, 8'h01);
    cyc(NS + 8);
    @(posedge clk);
    clk_en <= 1'b1;
    cyc(NS + 4);
    rd_chk(wim_pkg::ADDR_SRC_STAT, 8'h02);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
